/* design/rscol_pkg.sv */
// constants, field layout and status codes of the region start column register group
// Behaviour
// - the group is decoded from base address 0x1000 and every field offset is relative to that base.
// - offset zero is a read-only status byte: 0x00 absent, 0x01 present and valid, 0x80 a value out of range.
// - offset 0x0001 is a two-byte read/write field whose integer sets the first pixel of the region.
// - the start is at least 1 and moves in steps of 32 without pixel combining, 16 with it; software keeps to that grid.
// - the written integer is used directly as the first pixel position, 1 gives pixel 1, 33 gives pixel 33.
// - every two-byte field is stored low byte first, high byte at the next address.
// - offset 0x0003 is a read-only two-byte minimum start value, fixed at 1 whatever the other settings.
// - offset 0x0005 is a read-only two-byte maximum start value that follows the region length setting.
// - offset 0x0007 is a read-only two-byte field reporting the step that currently applies.
package rscol_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int FIELD_W = 16;
	localparam logic [ADDR_W-1:0] BASE_ADDR = 16'h1000;
	// byte offsets from the base
	localparam logic [ADDR_W-1:0] OFF_STATE = 16'h0000;
	localparam logic [ADDR_W-1:0] OFF_VALUE = 16'h0001;
	localparam logic [ADDR_W-1:0] OFF_LOWER = 16'h0003;
	localparam logic [ADDR_W-1:0] OFF_UPPER = 16'h0005;
	localparam logic [ADDR_W-1:0] OFF_STEP = 16'h0007;
	localparam logic [ADDR_W-1:0] OFF_EVENT = 16'h0009;
	localparam logic [ADDR_W-1:0] OFF_EVMASK = 16'h000A;
	// geometry and grid
	localparam logic [FIELD_W-1:0] SENSOR_PIXELS = 16'h0800;
	localparam logic [FIELD_W-1:0] START_MIN = 16'h0001;
	localparam logic [FIELD_W-1:0] STEP_PLAIN = 16'h0020;
	localparam logic [FIELD_W-1:0] STEP_BINNED = 16'h0010;
	localparam logic [FIELD_W-1:0] VALUE_RESET = 16'h0001;
	// event bits
	localparam int EV_RANGE = 0;
	localparam int EV_LIMIT = 1;
	localparam int EV_W = 2;
	localparam logic [EV_W-1:0] EV_RESET = 2'h0;
	localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
	typedef enum logic [7:0] {
		RSC_ABSENT = 8'h00,
		RSC_VALID = 8'h01,
		RSC_RANGE = 8'h80
	} rscol_state_t;
	// true when a byte address hits base plus offset
	function automatic logic rscol_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
		rscol_hit = (addr == BASE_ADDR + off);
	endfunction : rscol_hit
endpackage : rscol_pkg

/* design/rscol_limits.sv */
// legal range, step and out-of-range check for the region start
`timescale 1ns/100ps
module rscol_limits
	import rscol_pkg::*;
(
	input wire logic bin_enable,
	input wire logic [FIELD_W-1:0] window_length,
	input wire logic [FIELD_W-1:0] start_value,
	output logic [FIELD_W-1:0] lower_limit,
	output logic [FIELD_W-1:0] upper_limit,
	output logic [FIELD_W-1:0] step,
	output logic out_of_range
);
	logic [FIELD_W:0] span;
	logic [FIELD_W-1:0] offset;
	logic off_grid;

	// the last start that still fits the region inside the sensor line
	always_comb begin
		lower_limit = START_MIN;
		step = bin_enable ? STEP_BINNED : STEP_PLAIN;
		span = {1'b0, SENSOR_PIXELS} - {1'b0, window_length} + 17'h0_0001;
		// a region longer than the sensor leaves no legal start at all
		upper_limit = (window_length > SENSOR_PIXELS) ? 16'h0000 : span[FIELD_W-1:0];
		offset = start_value - START_MIN;
		// steps are powers of two, so the grid test is a look at the low bits
		off_grid = bin_enable ? (offset[3:0] != 4'h0) : (offset[4:0] != 5'h00);
		out_of_range = (start_value < lower_limit) || (start_value > upper_limit) || off_grid;
	end
endmodule : rscol_limits

/* design/rscol_field.sv */
// two-byte read/write field written one byte lane at a time
`timescale 1ns/100ps
module rscol_field
	import rscol_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic [DATA_W-1:0] wdata,
	output logic [FIELD_W-1:0] value
);
	logic [FIELD_W-1:0] value_r;
	logic [FIELD_W-1:0] value_nxt;

	// low byte at the lower address, high byte above it
	always_comb begin
		value_nxt = value_r;
		if (wr_low) begin
			value_nxt[7:0] = wdata;
		end
		if (wr_high) begin
			value_nxt[15:8] = wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			value_r <= VALUE_RESET;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign value = value_r;
endmodule : rscol_field

/* design/rscol_regs.sv */
// region start column register group with byte-wide register port and interrupt
`timescale 1ns/100ps
module rscol_regs
	import rscol_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_present,
	input wire logic bin_enable,
	input wire logic [FIELD_W-1:0] window_length,
	output logic [FIELD_W-1:0] window_start,
	output logic window_start_ok,
	output logic irq
);
	logic wr_start_lo;
	logic wr_start_hi;
	logic [FIELD_W-1:0] start_value;
	logic [FIELD_W-1:0] lower_limit;
	logic [FIELD_W-1:0] upper_limit;
	logic [FIELD_W-1:0] step;
	logic out_of_range;
	rscol_state_t state_now;
	rscol_state_t state_r;
	rscol_state_t state_nxt;
	logic [FIELD_W-1:0] upper_seen_r;
	logic [FIELD_W-1:0] upper_seen_nxt;
	logic [FIELD_W-1:0] step_seen_r;
	logic [FIELD_W-1:0] step_seen_nxt;
	logic [EV_W-1:0] event_r;
	logic [EV_W-1:0] event_nxt;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] mask_nxt;
	logic [EV_W-1:0] event_set;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [FIELD_W-1:0] start_out_r;
	logic [FIELD_W-1:0] start_out_nxt;
	logic ok_r;
	logic ok_nxt;

	// only the start field, the event byte and the event mask take writes; every other offset in the group drops them
	assign wr_start_lo = reg_wr && rscol_hit(reg_addr, OFF_VALUE);
	assign wr_start_hi = reg_wr && rscol_hit(reg_addr, OFF_VALUE + 16'h0001);

	rscol_field u_start (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr_low(wr_start_lo),
		.wr_high(wr_start_hi),
		.wdata(reg_wdata),
		.value(start_value)
	);

	rscol_limits u_limits (
		.bin_enable(bin_enable),
		.window_length(window_length),
		.start_value(start_value),
		.lower_limit(lower_limit),
		.upper_limit(upper_limit),
		.step(step),
		.out_of_range(out_of_range)
	);

	// status byte follows presence first, then the range check
	always_comb begin
		if (!reg_present) begin
			state_now = RSC_ABSENT;
		end else if (out_of_range) begin
			state_now = RSC_RANGE;
		end else begin
			state_now = RSC_VALID;
		end
		state_nxt = state_now;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_r <= RSC_ABSENT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// the start goes out untouched as the first pixel; no minus-one here,
	// pixel numbering starts at 1 on the downstream side as well
	always_comb begin
		start_out_nxt = start_value;
		ok_nxt = (state_now == RSC_VALID);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			start_out_r <= VALUE_RESET;
			ok_r <= 1'b0;
		end else begin
			start_out_r <= start_out_nxt;
			ok_r <= ok_nxt;
		end
	end

	// remember the last limits so a change of range raises an event
	always_comb begin
		upper_seen_nxt = upper_limit;
		step_seen_nxt = step;
		event_set = '0;
		// entering the out-of-range state, not staying in it
		event_set[EV_RANGE] = (state_now == RSC_RANGE) && (state_r != RSC_RANGE);
		event_set[EV_LIMIT] = (upper_limit != upper_seen_r) || (step != step_seen_r);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			upper_seen_r <= SENSOR_PIXELS;
			step_seen_r <= STEP_PLAIN;
		end else begin
			upper_seen_r <= upper_seen_nxt;
			step_seen_r <= step_seen_nxt;
		end
	end

	// sticky events, write one to clear; a new event in the clearing cycle wins
	always_comb begin
		event_nxt = event_r;
		mask_nxt = mask_r;
		if (reg_wr && rscol_hit(reg_addr, OFF_EVENT)) begin
			event_nxt = event_r & ~reg_wdata[EV_W-1:0];
		end
		event_nxt = event_nxt | event_set;
		if (reg_wr && rscol_hit(reg_addr, OFF_EVMASK)) begin
			mask_nxt = reg_wdata[EV_W-1:0];
		end
		irq_nxt = |(event_nxt & mask_nxt);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			event_r <= EV_RESET;
			mask_r <= MASK_RESET;
			irq_r <= 1'b0;
		end else begin
			event_r <= event_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// read mux; data stand only in the cycle after the strobe, zero elsewhere
	always_comb begin
		rdata_nxt = RDATA_IDLE;
		if (reg_rd) begin
			if (rscol_hit(reg_addr, OFF_STATE)) begin
				rdata_nxt = state_r;
			end else if (rscol_hit(reg_addr, OFF_VALUE)) begin
				rdata_nxt = start_value[7:0];
			end else if (rscol_hit(reg_addr, OFF_VALUE + 16'h0001)) begin
				rdata_nxt = start_value[15:8];
			end else if (rscol_hit(reg_addr, OFF_LOWER)) begin
				rdata_nxt = lower_limit[7:0];
			end else if (rscol_hit(reg_addr, OFF_LOWER + 16'h0001)) begin
				rdata_nxt = lower_limit[15:8];
			end else if (rscol_hit(reg_addr, OFF_UPPER)) begin
				rdata_nxt = upper_limit[7:0];
			end else if (rscol_hit(reg_addr, OFF_UPPER + 16'h0001)) begin
				rdata_nxt = upper_limit[15:8];
			end else if (rscol_hit(reg_addr, OFF_STEP)) begin
				rdata_nxt = step[7:0];
			end else if (rscol_hit(reg_addr, OFF_STEP + 16'h0001)) begin
				rdata_nxt = step[15:8];
			end else if (rscol_hit(reg_addr, OFF_EVENT)) begin
				rdata_nxt = {6'h00, event_r};
			end else if (rscol_hit(reg_addr, OFF_EVMASK)) begin
				rdata_nxt = {6'h00, mask_r};
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_r <= RDATA_IDLE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign window_start = start_out_r;
	assign window_start_ok = ok_r;
	assign irq = irq_r;
endmodule : rscol_regs

/* tb/rscol_regs_properties.sv */
// concurrent checks on the ports of the region start column register group
`timescale 1ns/100ps
module rscol_regs_checker
	import rscol_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_present,
	input wire logic bin_enable,
	input wire logic [FIELD_W-1:0] window_length,
	input wire logic [FIELD_W-1:0] window_start,
	input wire logic window_start_ok,
	input wire logic irq
);
	logic [7:0] max_lo;
	// expected upper limit low byte, zero when the window is wider than the sensor
	assign max_lo = (window_length > 16'h0800) ? 8'h00 : 8'h01 - window_length[7:0];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_UNMAPPED: assert property (reg_rd && (reg_addr < 16'h1000 || reg_addr > 16'h100A) |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	AST_ABSENT: assert property (reg_rd && reg_addr == 16'h1000 && !reg_present && !$past(reg_present) |=> !reg_rdata)
		else $error("status not absent");
	AST_MIN: assert property (reg_rd && reg_addr == 16'h1003 |=> reg_rdata == 8'h01)
		else $error("lower limit wrong");
	// the ok flag and the status byte come from the same registered verdict
	AST_OK: assert property (reg_rd && reg_addr == 16'h1000 |=> (reg_rdata == 8'h01) == $past(window_start_ok))
		else $error("ok flag disagrees with status byte");
	AST_HIGH_ZERO: assert property (reg_rd && (reg_addr == 16'h1004 || reg_addr == 16'h1008) |=> reg_rdata == 8'h00)
		else $error("high byte of limit or step wrong");
	AST_MAX: assert property (reg_rd && reg_addr == 16'h1005 |=> reg_rdata == $past(max_lo))
		else $error("upper limit low byte wrong");
	AST_STEP: assert property (reg_rd && reg_addr == 16'h1007 |=> reg_rdata == ($past(bin_enable) ? 8'h10 : 8'h20))
		else $error("step wrong");
	AST_START_LO: assert property (reg_wr && reg_addr == 16'h1001 |-> ##2 window_start[7:0] == $past(reg_wdata, 2))
		else $error("start low byte not applied");
	AST_START_HI: assert property (reg_wr && reg_addr == 16'h1002 |-> ##2 window_start[15:8] == $past(reg_wdata, 2))
		else $error("start high byte not applied");
endmodule : rscol_regs_checker
bind rscol_regs rscol_regs_checker u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_present(reg_present), .bin_enable(bin_enable),
	.window_length(window_length), .window_start(window_start), .window_start_ok(window_start_ok), .irq(irq));

/* tb/rscol_regs_tb.sv */
// self-checking bench for the region start column register group
`timescale 1ns/100ps
module rscol_regs_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_present = 1'b1;
	logic bin_enable = 1'b0;
	logic [15:0] window_length = 16'h0100;
	logic [7:0] reg_rdata;
	logic [15:0] window_start;
	logic window_start_ok;
	logic irq;
	int error_cnt = 0;
	int samples_checked = 0;
	rscol_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_present(reg_present), .bin_enable(bin_enable),
		.window_length(window_length), .window_start(window_start), .window_start_ok(window_start_ok), .irq(irq));
	// 100 ns clock
	initial begin
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// one-cycle write, then slack for the status and interrupt lag
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, e);
	endtask : rc
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	// main sequence; window length 0x100 gives an upper limit of 0x701
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rc(16'h1000, 8'h01);
		// limits are read before the first start write
		rc(16'h1003, 8'h01);
		rc(16'h1004, 8'h00);
		rc(16'h1005, 8'h01);
		rc(16'h1006, 8'h07);
		rc(16'h1007, 8'h20);
		rc(16'h1008, 8'h00);
		wr(16'h1001, 8'h21);
		wr(16'h1002, 8'h00);
		#1 chk("window_start", window_start, 16'h0021);
		rc(16'h1001, 8'h21);
		rc(16'h1002, 8'h00);
		rc(16'h1000, 8'h01);
		// off-grid start raises the event, but the mask holds irq low
		wr(16'h1001, 8'h22);
		rc(16'h1000, 8'h80);
		chk("window_start_ok", window_start_ok, 16'h0000);
		chk("irq", irq, 16'h0000);
		wr(16'h100A, 8'h01);
		#1 chk("irq", irq, 16'h0001);
		wr(16'h1001, 8'h21);
		wr(16'h1009, 8'h03);
		#1 chk("irq", irq, 16'h0000);
		rc(16'h1009, 8'h00);
		// upper limit itself is legal, one step above is not
		wr(16'h1002, 8'h07);
		wr(16'h1001, 8'h01);
		rc(16'h1000, 8'h01);
		chk("window_start_ok", window_start_ok, 16'h0001);
		#1 chk("window_start", window_start, 16'h0701);
		wr(16'h1001, 8'h21);
		rc(16'h1000, 8'h80);
		wr(16'h1002, 8'h00);
		wr(16'h1001, 8'h01);
		wr(16'h1003, 8'hFF);
		wr(16'h1007, 8'hFF);
		wr(16'h1000, 8'hFF);
		rc(16'h1003, 8'h01);
		rc(16'h1007, 8'h20);
		rc(16'h1000, 8'h01);
		rc(16'h2000, 8'h00);
		rc(16'h0FFF, 8'h00);
		@(posedge mclk);
		bin_enable <= 1'b1;
		rc(16'h1007, 8'h10);
		// range entries since the clear plus the step change are both pending, mask passes bit 0
		rc(16'h1009, 8'h03);
		chk("irq", irq, 16'h0001);
		wr(16'h1001, 8'h11);
		rc(16'h1000, 8'h01);
		@(posedge mclk);
		bin_enable <= 1'b0;
		repeat (3) @(posedge mclk);
		rc(16'h1000, 8'h80);
		@(posedge mclk);
		window_length <= 16'h0800;
		rc(16'h1005, 8'h01);
		rc(16'h1006, 8'h00);
		@(posedge mclk);
		reg_present <= 1'b0;
		repeat (3) @(posedge mclk);
		rc(16'h1000, 8'h00);
		summarize();
	end
	// cut a hang short; the sequence needs about 150 cycles
	initial begin
		repeat (3000) @(posedge mclk);
		error_cnt++;
		summarize();
	end
endmodule : rscol_regs_tb
